// ==== shared/sdram_pkg.sv ====
// Shared constants, types and decode helpers for both SDRAM link ends
package sdram_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ACT_TO_ACCESS_NS = 20;
	localparam int SAME_BANK_ACT_NS = 60;
	localparam int CROSS_BANK_ACT_NS = 15;
	localparam int PRECHARGE_NS = 20;

	// Least times round up to whole cycles, never below one
	function automatic int ns_to_clk(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_clk

	localparam int ACT_TO_ACCESS_CLK = ns_to_clk(ACT_TO_ACCESS_NS);
	localparam int SAME_BANK_ACT_CLK = ns_to_clk(SAME_BANK_ACT_NS);
	localparam int CROSS_BANK_ACT_CLK = ns_to_clk(CROSS_BANK_ACT_NS);
	localparam int PRECHARGE_CLK = ns_to_clk(PRECHARGE_NS);

	// ---------------------------------------------------------------
	// Geometry and field positions
	// ---------------------------------------------------------------
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ADDR_W = 12;
	localparam int COL_W = 9;
	localparam int DATA_W = 16;
	localparam int TIMER_W = 5;
	localparam int AUTO_PRECHARGE_BIT = 10;

	// ---------------------------------------------------------------
	// Mode encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] READ_LATENCY_LONG = 2'h3;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;

	typedef enum logic [2:0] {CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_BURST_TERM} cmd_e;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_TERMINATE, OP_PRECHARGE} op_e;

	// Elements per burst; zero stands for a full page
	function automatic logic [COL_W:0] burst_len(input logic [2:0] code);
		case (code)
			BL_1: return (COL_W+1)'(1);
			BL_2: return (COL_W+1)'(2);
			BL_4: return (COL_W+1)'(4);
			BL_8: return (COL_W+1)'(8);
			default: return '0;
		endcase
	endfunction : burst_len
endpackage : sdram_pkg

// ==== shared/sdram_if.sv ====
// Command, mask and data lines between the controller end and the SDRAM end
`timescale 1ns/100ps
interface sdram_if;
	import sdram_pkg::*;
	cmd_e cmd;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic dqm;
	logic [DATA_W-1:0] ctl_dq;
	logic ctl_dq_oe;
	logic [DATA_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic [DATA_W-1:0] dq;

	// Resolved bus level; with both enables high the device value is shown
	assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

	modport device (input cmd, bank, addr, dqm, dq, output dev_dq, dev_dq_oe);
	modport controller (output cmd, bank, addr, dqm, ctl_dq, ctl_dq_oe, input dq, dev_dq_oe);
endinterface : sdram_if

// ==== rtl/dram_timer.sv ====
// Down-counter that tells when a minimum command spacing has elapsed
`timescale 1ns/100ps
module dram_timer #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic start,
	input wire logic [W-1:0] cycles,
	// Status
	output logic done,
	output logic done_next
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= cycles - W'(1);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign done = (cnt_q == '0);
	// Lets a registered command stage look one edge ahead
	assign done_next = start ? (cycles <= W'(1)) : (cnt_q <= W'(1));
endmodule : dram_timer

// ==== rtl/sdram_device.sv ====
// SDRAM end: bank state, read bursts, latency pipeline and data drive
`timescale 1ns/100ps
// Operation
// [R1] Row must be opened before column access
// [R2] Wait activate-to-access delay before access
// [R3] Same-bank reopen needs precharge and interval
// [R4] Cross-bank activates spaced by their interval
// [R5] Auto precharge closes row after burst
// [R6] First element after read latency, then each edge
// [R7] Data pins float when burst completes
// [R8] Full page runs on, wraps to column zero
// [R9] Later read truncates or chains gaplessly
// [R10] Read accepted every cycle, any bank
// [R11] Write follows read with turnaround gap
// [R12] Mask raised two clocks before truncating write
// [R13] Write floats pins; unmasked prior clock invalid
// [R14] Mask lowered at write for input data
// [R15] Precharge truncates read at latency minus one
// [R16] No same-bank command inside precharge period
// [R17] Timed explicit precharge equals auto precharge
// [R18] Burst terminate cuts read, latency minus one
// [R19] Address bit selects auto precharge per command
// [R20] Per-bank idle or open state with row
module sdram_device (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Mode settings
	input wire logic [1:0] READ_LATENCY,
	input wire logic [2:0] BURST_LEN,
	// Memory link
	sdram_if.device MEM,
	// Status
	output logic [sdram_pkg::NUM_BANKS-1:0] BANK_OPEN,
	output logic BURST_ACTIVE,
	output logic TIMING_ERR,
	output logic INVALID_WRITE
);
	import sdram_pkg::*;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bt;
	logic ap_bit;

	assign is_act = (MEM.cmd == CMD_ACTIVE);
	assign is_rd = (MEM.cmd == CMD_READ);
	assign is_wr = (MEM.cmd == CMD_WRITE);
	assign is_pre = (MEM.cmd == CMD_PRECHARGE);
	assign is_bt = (MEM.cmd == CMD_BURST_TERM);
	assign ap_bit = MEM.addr[AUTO_PRECHARGE_BIT]; // [R19]

	// Read data is a fixed function of its location; writes are not stored here
	function automatic logic [DATA_W-1:0] data_word(input logic [BANK_W-1:0] bk,
		input logic [ADDR_W-1:0] row, input logic [COL_W-1:0] col);
		return DATA_W'({row, bk, col});
	endfunction : data_word

	// ---------------------------------------------------------------
	// Burst state
	// ---------------------------------------------------------------
	logic burst_q;
	logic full_q;
	logic bap_q;
	logic [BANK_W-1:0] bbank_q;
	logic [COL_W-1:0] bcol_q;
	logic [COL_W-1:0] bmask_q;
	logic [COL_W:0] left_q;
	logic [COL_W:0] blen;
	logic [NUM_BANKS-1:0] open_q;
	logic [ADDR_W-1:0] row_all [NUM_BANKS];
	logic rd_ok;
	logic burst_end;
	logic ap_close;
	logic stop_burst;

	assign blen = burst_len(BURST_LEN);
	assign rd_ok = is_rd & open_q[MEM.bank];
	assign burst_end = burst_q & ~full_q & (left_q == '0);
	// Closing at this edge matches an explicit precharge at the best slot
	assign ap_close = burst_end & bap_q; // [R5] [R17]
	// On terminate or precharge in-flight elements still drain, so the cut lands latency minus one later; a write cuts them at once
	assign stop_burst = is_bt | is_wr | (is_pre & (ap_bit | (MEM.bank == bbank_q))); // [R15] [R18]

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			burst_q <= 1'b0;
			full_q <= 1'b0;
			bap_q <= 1'b0;
			bbank_q <= '0;
			bcol_q <= '0;
			bmask_q <= '0;
			left_q <= '0;
		end else if (rd_ok) begin // [R9] [R10]
			burst_q <= 1'b1;
			full_q <= (BURST_LEN == BL_FULL);
			bap_q <= ap_bit & (BURST_LEN != BL_FULL); // [R5]
			bbank_q <= MEM.bank;
			bcol_q <= MEM.addr[COL_W-1:0];
			bmask_q <= (BURST_LEN == BL_FULL) ? '1 : COL_W'(blen - (COL_W+1)'(1));
			left_q <= blen - (COL_W+1)'(1);
		end else if (stop_burst | burst_end) begin
			burst_q <= 1'b0; // [R7]
		end else if (burst_q) begin
			bcol_q <= (bcol_q & ~bmask_q) | ((bcol_q + COL_W'(1)) & bmask_q); // [R8]
			left_q <= left_q - (COL_W+1)'(1);
		end
	end

	// ---------------------------------------------------------------
	// Bank state and spacing checks
	// ---------------------------------------------------------------
	logic [NUM_BANKS-1:0] bank_err;
	logic rrd_done;

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic sel;
			logic act_start;
			logic pre_hit;
			logic open_bq;
			logic [ADDR_W-1:0] row_bq;
			logic rcd_done;
			logic rc_done;
			logic rp_done;

			assign sel = (MEM.bank == BANK_W'(b));
			assign act_start = is_act & sel;
			assign pre_hit = (is_pre & (sel | ap_bit)) | (ap_close & (bbank_q == BANK_W'(b)));

			always_ff @(posedge SYS_CLK) begin
				if (SRST) begin
					open_bq <= 1'b0;
					row_bq <= '0;
				end else if (act_start & ~open_bq) begin // [R1] [R20]
					open_bq <= 1'b1;
					row_bq <= MEM.addr;
				end else if (pre_hit) begin
					open_bq <= 1'b0; // [R20]
				end
			end

			assign open_q[b] = open_bq;
			assign row_all[b] = row_bq;

			dram_timer #(.W(TIMER_W)) u_rcd (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(act_start),
				.cycles(TIMER_W'(ACT_TO_ACCESS_CLK)),
				.done(rcd_done),
				.done_next()
			);
			dram_timer #(.W(TIMER_W)) u_rc (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(act_start),
				.cycles(TIMER_W'(SAME_BANK_ACT_CLK)),
				.done(rc_done),
				.done_next()
			);
			dram_timer #(.W(TIMER_W)) u_rp (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(pre_hit),
				.cycles(TIMER_W'(PRECHARGE_CLK)),
				.done(rp_done),
				.done_next()
			);

			// Misplaced commands are flagged; a closed-bank read is also dropped
			assign bank_err[b] = sel & ((is_act & (open_bq | ~rc_done | ~rp_done)) // [R3] [R16]
				| ((is_rd | is_wr) & (~open_bq | ~rcd_done))); // [R1] [R2]
		end
	endgenerate

	dram_timer #(.W(TIMER_W)) u_rrd (
		.clk(SYS_CLK),
		.srst(SRST),
		.start(is_act),
		.cycles(TIMER_W'(CROSS_BANK_ACT_CLK)),
		.done(rrd_done),
		.done_next()
	);

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			TIMING_ERR <= 1'b0;
		end else begin
			TIMING_ERR <= (|bank_err) | (is_act & ~rrd_done); // [R4]
		end
	end

	// ---------------------------------------------------------------
	// Latency pipeline and output drive
	// ---------------------------------------------------------------
	logic pipe_valid_q;
	logic [DATA_W-1:0] pipe_data_q;
	logic [DATA_W-1:0] fetch_data;
	logic dqm_q;
	logic oe_q;
	logic [DATA_W-1:0] dq_q;
	logic long_lat;
	logic tap_valid;
	logic [DATA_W-1:0] tap_data;

	assign fetch_data = data_word(bbank_q, row_all[bbank_q], bcol_q);
	assign long_lat = (READ_LATENCY == READ_LATENCY_LONG);
	assign tap_valid = long_lat ? pipe_valid_q : burst_q; // [R6]
	assign tap_data = long_lat ? pipe_data_q : fetch_data;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			pipe_valid_q <= 1'b0;
			pipe_data_q <= '0;
		end else begin
			pipe_valid_q <= burst_q & ~is_wr; // [R13]
			pipe_data_q <= fetch_data;
		end
	end

	// Mask is taken one edge and applied on the output loaded the next
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			dqm_q <= 1'b0;
			oe_q <= 1'b0;
			dq_q <= '0;
		end else begin
			dqm_q <= MEM.dqm;
			oe_q <= tap_valid & ~dqm_q & ~is_wr; // [R7] [R12] [R13]
			dq_q <= tap_data;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			INVALID_WRITE <= 1'b0;
		end else begin
			INVALID_WRITE <= is_wr & ~dqm_q & (burst_q | pipe_valid_q | oe_q); // [R13]
		end
	end

	assign MEM.dev_dq = dq_q;
	assign MEM.dev_dq_oe = oe_q;
	assign BANK_OPEN = open_q;
	assign BURST_ACTIVE = burst_q;
endmodule : sdram_device

// ==== rtl/sdram_ctrl.sv ====
// Controller end: opens rows, spaces commands, masks turnaround, returns read data
`timescale 1ns/100ps
module sdram_ctrl (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Mode setting, same value as the device
	input wire logic [2:0] BURST_LEN,
	// Requests
	input wire logic REQ_VALID,
	input wire sdram_pkg::op_e REQ_OP,
	input wire logic [sdram_pkg::BANK_W-1:0] REQ_BANK,
	input wire logic [sdram_pkg::ADDR_W-1:0] REQ_ROW,
	input wire logic [sdram_pkg::COL_W-1:0] REQ_COL,
	input wire logic REQ_AUTO_PRE,
	input wire logic [sdram_pkg::DATA_W-1:0] REQ_WDATA,
	output logic REQ_READY,
	// Read data
	output logic [sdram_pkg::DATA_W-1:0] RD_DATA,
	output logic RD_VALID,
	// Memory link
	sdram_if.controller MEM
);
	import sdram_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_MASK} state_e;

	state_e state_q, state_d;
	op_e op_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] row_q;
	logic [COL_W-1:0] col_q;
	logic ap_q;
	logic [DATA_W-1:0] wdata_q;
	cmd_e cmd_q, cmd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic dqm_q, dqm_d;
	logic oe_q, oe_d;
	logic mask_q;
	logic ap_use;
	logic [NUM_BANKS-1:0] open_m, hit_m, rcd_m, act_m;
	logic rrd_next;

	// Auto precharge has no meaning on a full-page burst
	assign ap_use = ap_q & (op_q == OP_READ) & (BURST_LEN != BL_FULL); // [R19]

	// ---------------------------------------------------------------
	// Mirror of bank state, fed by the command as the device takes it
	// ---------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic sel;
			logic act_s;
			logic pre_s;
			logic apr_s;
			logic open_bq;
			logic [ADDR_W-1:0] row_bq;
			logic rc_next;
			logic rp_next;

			assign sel = (MEM.bank == BANK_W'(b));
			assign act_s = (cmd_q == CMD_ACTIVE) & sel;
			assign pre_s = (cmd_q == CMD_PRECHARGE) & (sel | MEM.addr[AUTO_PRECHARGE_BIT]);
			assign apr_s = (cmd_q == CMD_READ) & sel & MEM.addr[AUTO_PRECHARGE_BIT];

			always_ff @(posedge SYS_CLK) begin
				if (SRST) begin
					open_bq <= 1'b0;
					row_bq <= '0;
				end else if (act_s) begin
					open_bq <= 1'b1; // [R1]
					row_bq <= MEM.addr;
				end else if (pre_s | apr_s) begin
					open_bq <= 1'b0;
				end
			end

			dram_timer #(.W(TIMER_W)) u_rcd (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(act_s),
				.cycles(TIMER_W'(ACT_TO_ACCESS_CLK)),
				.done(),
				.done_next(rcd_m[b])
			);
			dram_timer #(.W(TIMER_W)) u_rc (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(act_s),
				.cycles(TIMER_W'(SAME_BANK_ACT_CLK)),
				.done(),
				.done_next(rc_next)
			);
			// An auto-precharged bank frees once its burst and the period have run
			dram_timer #(.W(TIMER_W)) u_rp (
				.clk(SYS_CLK),
				.srst(SRST),
				.start(pre_s | apr_s),
				.cycles(apr_s ? TIMER_W'(PRECHARGE_CLK + int'(burst_len(BURST_LEN))) : TIMER_W'(PRECHARGE_CLK)),
				.done(),
				.done_next(rp_next)
			); // [R16]

			assign open_m[b] = open_bq;
			assign hit_m[b] = open_bq & (row_bq == row_q);
			assign act_m[b] = rc_next & rp_next; // [R3]
		end
	endgenerate

	dram_timer #(.W(TIMER_W)) u_rrd (
		.clk(SYS_CLK),
		.srst(SRST),
		.start(cmd_q == CMD_ACTIVE),
		.cycles(TIMER_W'(CROSS_BANK_ACT_CLK)),
		.done(),
		.done_next(rrd_next)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// One command at most every other cycle, so the mirror is settled at each choice
	always_comb begin
		state_d = state_q;
		cmd_d = CMD_NOP;
		addr_d = addr_q;
		dqm_d = 1'b0;
		oe_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (REQ_VALID) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (cmd_q == CMD_NOP) begin
					if (op_q == OP_TERMINATE) begin
						cmd_d = CMD_BURST_TERM; // [R18]
						state_d = ST_IDLE;
					end else if (op_q == OP_PRECHARGE) begin
						cmd_d = CMD_PRECHARGE; // [R15]
						addr_d = '0;
						state_d = ST_IDLE;
					end else if (open_m[bank_q] & ~hit_m[bank_q]) begin
						cmd_d = CMD_PRECHARGE; // [R3]
						addr_d = '0;
					end else if (~open_m[bank_q]) begin
						if (act_m[bank_q] & rrd_next) begin // [R4]
							cmd_d = CMD_ACTIVE;
							addr_d = row_q;
						end
					end else if (rcd_m[bank_q]) begin // [R2]
						if (op_q == OP_WRITE) begin
							dqm_d = 1'b1; // [R12]
							state_d = ST_MASK;
						end else begin
							cmd_d = CMD_READ; // [R9]
							addr_d = ADDR_W'(col_q);
							addr_d[AUTO_PRECHARGE_BIT] = ap_use;
							state_d = ST_IDLE;
						end
					end
				end
			end
			ST_MASK: begin
				if (!mask_q) begin
					dqm_d = 1'b1; // [R11] [R12] [R13]
				end else begin
					cmd_d = CMD_WRITE; // [R14]
					addr_d = ADDR_W'(col_q);
					oe_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_q <= ST_IDLE;
			mask_q <= 1'b0;
			REQ_READY <= 1'b0;
		end else begin
			state_q <= state_d;
			mask_q <= (state_q == ST_MASK) & ~mask_q;
			REQ_READY <= (state_d == ST_IDLE);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			op_q <= OP_READ;
			bank_q <= '0;
			row_q <= '0;
			col_q <= '0;
			ap_q <= 1'b0;
			wdata_q <= '0;
		end else if (REQ_VALID & REQ_READY) begin
			op_q <= REQ_OP;
			bank_q <= REQ_BANK;
			row_q <= REQ_ROW;
			col_q <= REQ_COL;
			ap_q <= REQ_AUTO_PRE;
			wdata_q <= REQ_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cmd_q <= CMD_NOP;
			addr_q <= '0;
			dqm_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			dqm_q <= dqm_d;
			oe_q <= oe_d;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
		end else begin
			RD_VALID <= MEM.dev_dq_oe;
			RD_DATA <= MEM.dq;
		end
	end

	assign MEM.cmd = cmd_q;
	assign MEM.bank = bank_q;
	assign MEM.addr = addr_q;
	assign MEM.dqm = dqm_q;
	assign MEM.ctl_dq = wdata_q;
	assign MEM.ctl_dq_oe = oe_q;
endmodule : sdram_ctrl

// ==== verification/sdram_link_sva.sv ====
// Interface checker: command spacing, read timing and bus turnaround
`timescale 1ns/100ps
module sdram_link_sva (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Mode
	input wire logic [1:0] READ_LATENCY,
	// Link
	input wire sdram_pkg::cmd_e cmd,
	input wire logic [sdram_pkg::BANK_W-1:0] bank,
	input wire logic [sdram_pkg::ADDR_W-1:0] addr,
	input wire logic dqm,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe
);
	import sdram_pkg::*;
	// ---------------------------------------------------------------
	// Per-bank ages in edges since the command, saturating so nothing is owed after reset
	// ---------------------------------------------------------------
	logic [4:0] act_age_q [NUM_BANKS];
	logic [4:0] pre_age_q [NUM_BANKS];
	logic [NUM_BANKS-1:0] open_q;
	always_ff @(posedge SYS_CLK) begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (SRST || (cmd == CMD_ACTIVE && bank == BANK_W'(b))) begin
				act_age_q[b] <= SRST ? 5'h1F : 5'h01;
			end else if (act_age_q[b] != 5'h1F) begin
				act_age_q[b] <= act_age_q[b] + 5'h01;
			end
			if (SRST || (cmd == CMD_PRECHARGE && (bank == BANK_W'(b) || addr[AUTO_PRECHARGE_BIT]))) begin
				pre_age_q[b] <= SRST ? 5'h1F : 5'h01;
			end else if (pre_age_q[b] != 5'h1F) begin
				pre_age_q[b] <= pre_age_q[b] + 5'h01;
			end
		end
	end
	// Auto precharge is not tracked, so this only ever errs towards open
	always_ff @(posedge SYS_CLK) begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (SRST) begin
				open_q[b] <= 1'b0;
			end else if (cmd == CMD_ACTIVE && bank == BANK_W'(b)) begin
				open_q[b] <= 1'b1;
			end else if (cmd == CMD_PRECHARGE && (bank == BANK_W'(b) || addr[AUTO_PRECHARGE_BIT])) begin
				open_q[b] <= 1'b0;
			end
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	sequence read_short_s;
		cmd == CMD_READ && READ_LATENCY != READ_LATENCY_LONG && !dqm;
	endsequence
	sequence read_long_s;
		cmd == CMD_READ && READ_LATENCY == READ_LATENCY_LONG ##1 !dqm;
	endsequence
	read_cl2_a: assert property (read_short_s |-> ##2 dev_dq_oe) else $error("no data two edges after read");
	read_cl3_a: assert property (read_long_s |-> ##2 dev_dq_oe) else $error("no data three edges after read");
	write_floats_a: assert property (cmd == CMD_WRITE |=> !dev_dq_oe [*2]) else $error("device drives after write");
	mask_lead_a: assert property (cmd == CMD_WRITE |-> $past(dqm, 1) && $past(dqm, 2)) else $error("mask not early");
	mask_drop_a: assert property (cmd == CMD_WRITE |-> !dqm && ctl_dq_oe) else $error("write data masked");
	no_contend_a: assert property (ctl_dq_oe |-> !dev_dq_oe) else $error("both ends drive data");
	row_open_a: assert property (cmd inside {CMD_READ, CMD_WRITE} |-> open_q[bank]) else $error("access to idle bank");
	act_access_a: assert property (cmd inside {CMD_READ, CMD_WRITE} |-> act_age_q[bank] >= ACT_TO_ACCESS_CLK)
		else $error("access too soon after activate");
	same_bank_a: assert property (cmd == CMD_ACTIVE |-> act_age_q[bank] >= SAME_BANK_ACT_CLK)
		else $error("same bank activates too close");
	cross_bank_a: assert property (cmd == CMD_ACTIVE |=> cmd != CMD_ACTIVE [*2]) else $error("activates too close");
	pre_period_a: assert property (cmd == CMD_ACTIVE |-> pre_age_q[bank] >= PRECHARGE_CLK)
		else $error("activate inside precharge period");
endmodule : sdram_link_sva

// ==== verification/sdram_activate_read_sequencing_tb_top.sv ====
// Bench: controller end and SDRAM end joined over the link, driven from the request side
`timescale 1ns/100ps
module sdram_activate_read_sequencing_tb_top;
	import sdram_pkg::*;
	logic SYS_CLK = 1'b0;
	logic SRST = 1'b1;
	logic [1:0] READ_LATENCY = 2'h2;
	logic [2:0] BURST_LEN = 3'h1;
	logic REQ_VALID = 1'b0;
	op_e REQ_OP = OP_READ;
	logic [BANK_W-1:0] REQ_BANK = 2'h0;
	logic [ADDR_W-1:0] REQ_ROW = 12'h000;
	logic [COL_W-1:0] REQ_COL = 9'h000;
	logic REQ_AUTO_PRE = 1'b0;
	logic [DATA_W-1:0] REQ_WDATA = 16'hA5A5;
	logic REQ_READY, RD_VALID, BURST_ACTIVE, TIMING_ERR, INVALID_WRITE;
	logic [DATA_W-1:0] RD_DATA;
	logic [NUM_BANKS-1:0] BANK_OPEN;
	logic [DATA_W-1:0] rd_q [$];
	int fails = 0;
	int total_checks = 0;
	int flag_cnt = 0;
	sdram_if link();
	sdram_ctrl i_sdram_ctrl (.SYS_CLK(SYS_CLK), .SRST(SRST), .BURST_LEN(BURST_LEN), .REQ_VALID(REQ_VALID),
		.REQ_OP(REQ_OP), .REQ_BANK(REQ_BANK), .REQ_ROW(REQ_ROW), .REQ_COL(REQ_COL), .REQ_AUTO_PRE(REQ_AUTO_PRE),
		.REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .MEM(link.controller));
	sdram_device i_sdram_device (.SYS_CLK(SYS_CLK), .SRST(SRST), .READ_LATENCY(READ_LATENCY), .BURST_LEN(BURST_LEN),
		.MEM(link.device), .BANK_OPEN(BANK_OPEN), .BURST_ACTIVE(BURST_ACTIVE), .TIMING_ERR(TIMING_ERR),
		.INVALID_WRITE(INVALID_WRITE));
	sdram_link_sva i_sdram_link_sva (.SYS_CLK(SYS_CLK), .SRST(SRST), .READ_LATENCY(READ_LATENCY), .cmd(link.cmd),
		.bank(link.bank), .addr(link.addr), .dqm(link.dqm), .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));
	initial begin
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end
	// Flags and returned words are sampled mid-cycle, clear of the launching edge
	always @(negedge SYS_CLK) begin
		if (!SRST && RD_VALID === 1'b1)
			rd_q.push_back(RD_DATA);
		if (!SRST && (TIMING_ERR !== 1'b0 || INVALID_WRITE !== 1'b0))
			flag_cnt++;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	function automatic logic [15:0] word(input logic [11:0] row, input logic [1:0] b, input logic [8:0] col);
		return {row[4:0], b, col};
	endfunction : word
	task automatic cycles(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask : cycles
	task automatic wait_ready();
		int n;
		n = 0;
		while (REQ_READY !== 1'b1 && n < 100) begin
			@(negedge SYS_CLK);
			n++;
		end
		check("req_ready", n < 100, 32'h1);
	endtask : wait_ready
	task automatic request(input op_e op, input logic [1:0] b, input logic [11:0] row, input logic [8:0] col,
		input logic ap);
		wait_ready();
		REQ_VALID = 1'b1;
		REQ_OP = op;
		REQ_BANK = b;
		REQ_ROW = row;
		REQ_COL = col;
		REQ_AUTO_PRE = ap;
		@(negedge SYS_CLK);
		REQ_VALID = 1'b0;
	endtask : request
	// Fixed burst: count, start column and wrap inside the aligned block
	task automatic read_burst(input logic [1:0] b, input logic [11:0] row, input logic [8:0] col, input int bl,
		input logic ap);
		rd_q.delete();
		request(OP_READ, b, row, col, ap);
		cycles(50);
		check("burst_count", rd_q.size(), bl);
		foreach (rd_q[i])
			check("burst_word", rd_q[i], word(row, b, 9'((col & ~(bl - 1)) | ((col + i) & (bl - 1)))));
	endtask : read_burst
	// Every latency and fixed length; second pass changes each bank's row
	task automatic s_bursts();
		for (int cl = 2; cl <= 3; cl++) begin
			for (int k = 0; k < 4; k++) begin
				READ_LATENCY = (cl == 3) ? 2'h3 : 2'h2;
				BURST_LEN = 3'(k);
				read_burst(2'(k), 12'(cl * 16 + k), 9'(9'h0F3 + k), 1 << k, 1'b0);
			end
		end
	endtask : s_bursts
	task automatic s_auto_pre();
		BURST_LEN = BL_4;
		read_burst(2'h1, 12'h0A1, 9'h005, 4, 1'b1);
		check("auto_closed", BANK_OPEN[1], 32'h0);
		read_burst(2'h2, 12'h0A2, 9'h006, 4, 1'b0);
		check("kept_open", BANK_OPEN[2], 32'h1);
		read_burst(2'h1, 12'h0A1, 9'h007, 4, 1'b0);
	endtask : s_auto_pre
	// Full page read cut by terminate, write or precharge
	task automatic s_trunc(input op_e op);
		int n;
		BURST_LEN = BL_FULL;
		rd_q.delete();
		request(OP_READ, 2'h3, 12'h033, 9'h1FE, 1'b0);
		wait_ready();
		cycles(6);
		request(op, 2'h3, 12'h033, 9'h000, 1'b0);
		cycles(20);
		n = rd_q.size();
		check("trunc_len", n >= 3, 32'h1);
		for (int i = 0; i < 3 && i < n; i++)
			check("page_word", rd_q[i], word(12'h033, 2'h3, 9'(9'h1FE + i)));
		cycles(20);
		check("trunc_stop", rd_q.size(), n);
		check("burst_idle", BURST_ACTIVE, 32'h0);
		check("bank_state", BANK_OPEN[3], 32'(op != OP_PRECHARGE));
	endtask : s_trunc
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		fails++;
		stop_test();
	end
	initial begin
		repeat (5) @(negedge SYS_CLK);
		SRST = 1'b0;
		s_bursts();
		s_auto_pre();
		s_trunc(OP_TERMINATE);
		s_trunc(OP_WRITE);
		s_trunc(OP_PRECHARGE);
		check("flag_pulses", flag_cnt, 0);
		stop_test();
	end
endmodule : sdram_activate_read_sequencing_tb_top
